// ===== bench/cxm_chk.sv
// Checker for the channel bus master cycle
`timescale 1ns/10ps
`default_nettype none
module cxm_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic busAddrOe,
	input wire logic statusLineA_n,
	input wire logic statusLineB_n,
	input wire logic command_n,
	input wire logic highByteLaneEnable_n,
	input wire logic [3:0] byteEnable_n,
	input wire logic byteEnableTranslateSelect_n,
	input wire logic dmaFinalCountPulse_n,
	input wire logic dataOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Address settles a cycle ahead of either status line
	wr_addr_first_a: assert property (
		$fell(statusLineA_n) |-> $past(busAddrOe)) else $error("status a early");
	rd_addr_first_a: assert property (
		$fell(statusLineB_n) |-> $past(busAddrOe)) else $error("status b early");
	wr_data_held_a: assert property (
		!command_n && !statusLineA_n |-> dataOe ##1 dataOe)
		else $error("write data dropped");
	rd_no_drive_a: assert property (
		!statusLineB_n |-> !dataOe) else $error("master drives on read");
	xlate_off_a: assert property (
		byteEnableTranslateSelect_n) else $error("translate select active");
	fc_in_cmd_a: assert property (
		!dmaFinalCountPulse_n |-> !command_n) else $error("final count stray");
	cmd_width_a: assert property (
		$fell(command_n) |-> !command_n[*3] ##1 command_n)
		else $error("command width");
	stat_legal_a: assert property (
		statusLineA_n || statusLineB_n) else $error("both status low");
	lane_high_a: assert property (
		busAddrOe |-> highByteLaneEnable_n == (byteEnable_n[1] & byteEnable_n[3]))
		else $error("high lane enable");
endmodule : cxm_chk
bind cxm_master cxm_chk cxm_chk_inst (.clk(clk), .rst(rst),
	.busAddrOe(busAddrOe), .statusLineA_n(statusLineA_n),
	.statusLineB_n(statusLineB_n), .command_n(command_n),
	.highByteLaneEnable_n(highByteLaneEnable_n), .byteEnable_n(byteEnable_n),
	.byteEnableTranslateSelect_n(byteEnableTranslateSelect_n),
	.dmaFinalCountPulse_n(dmaFinalCountPulse_n), .dataOe(dataOe));
`default_nettype wire

// ===== bench/cxm_slave_model.sv
// Behavioural slave on the channel bus
`timescale 1ns/10ps
`default_nettype none
module cxm_slave_model (
	input wire logic clk,
	input wire logic [23:0] busAddr,
	input wire logic memIoSelect,
	input wire logic statusLineA_n,
	input wire logic statusLineB_n,
	input wire logic command_n,
	input wire logic dmaFinalCountPulse_n,
	input wire logic [31:0] dataOut,
	output logic [31:0] dataIn,
	output logic [31:0] wrData,
	output logic [24:0] wrAddr,
	output logic fcSeen
);
	logic [31:0] junk = 32'h0f0f0f0f;
	logic rdCmd;
	// Junk flips every cycle so a stale value never passes as data
	assign rdCmd = !command_n && !statusLineB_n && statusLineA_n;
	assign dataIn = rdCmd ? {8'h5a, busAddr} : junk;
	// Writes are taken only while the command is low
	always_ff @(posedge clk) begin
		junk <= ~junk;
		if (!command_n && !statusLineA_n && statusLineB_n) begin
			wrData <= dataOut;
			wrAddr <= {memIoSelect, busAddr};
		end
		if (!command_n) fcSeen <= !dmaFinalCountPulse_n;
	end
endmodule : cxm_slave_model
`default_nettype wire

// ===== bench/test_cxm_master.sv
// Self-checking bench for the channel bus master
`timescale 1ns/10ps
`default_nettype none
module test_cxm_master;
	logic clk = 0, rst = 1, reqValid = 0, reqWrite = 0, reqMemory = 0;
	logic reqLast = 0, reqReady, rspValid, busAddrOe, memIoSelect, dataOe;
	logic statusLineA_n, statusLineB_n, command_n, dmaFinalCountPulse_n, fcSeen;
	logic [23:0] reqAddr = 0, busAddr;
	logic [31:0] reqData = 0, rspData, dataOut, dataIn, wrData;
	logic [3:0] reqByteEn = 0, byteEnable_n;
	logic [24:0] wrAddr;
	int errTotal = 0, nChecks = 0, cyc = 0, rspSeen = 0;
	always #50 clk = ~clk;
	cxm_master cxm_master_inst (.clk(clk), .rst(rst), .reqValid(reqValid),
		.reqReady(reqReady), .reqWrite(reqWrite), .reqMemory(reqMemory),
		.reqLast(reqLast), .reqAddr(reqAddr), .reqData(reqData),
		.reqByteEn(reqByteEn), .rspValid(rspValid), .rspData(rspData),
		.busAddr(busAddr), .busAddrOe(busAddrOe), .memIoSelect(memIoSelect),
		.statusLineA_n(statusLineA_n), .statusLineB_n(statusLineB_n),
		.command_n(command_n), .highByteLaneEnable_n(),
		.byteEnable_n(byteEnable_n), .byteEnableTranslateSelect_n(),
		.dmaFinalCountPulse_n(dmaFinalCountPulse_n), .dataOut(dataOut),
		.dataOe(dataOe), .dataIn(dataIn));
	cxm_slave_model cxm_slave_model_inst (.clk(clk), .busAddr(busAddr),
		.memIoSelect(memIoSelect), .statusLineA_n(statusLineA_n),
		.statusLineB_n(statusLineB_n), .command_n(command_n),
		.dmaFinalCountPulse_n(dmaFinalCountPulse_n), .dataOut(dataOut),
		.dataIn(dataIn), .wrData(wrData), .wrAddr(wrAddr), .fcSeen(fcSeen));
	task chk(input logic [31:0] got, exp);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task reportAndStop;
		$display("errors %0d checks %0d", errTotal, nChecks);
		if (errTotal == 0 && nChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : reportAndStop
	// One bus cycle; returns once the master is idle again
	task xfer(input logic w, m, l, input logic [23:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int i;
		int expCyc;
		// Address, status, command and hold phases
		expCyc = cxm_pkg::ADDR_SETUP_CYC + 1 + cxm_pkg::CMD_WIDTH_CYC +
			cxm_pkg::HOLD_CYC;
		{reqWrite, reqMemory, reqLast, reqAddr, reqData, reqByteEn} =
			{w, m, l, a, d, be};
		rspSeen = 0;
		reqValid = 1;
		@(posedge clk);
		#1 reqValid = 0;
		for (i = 0; i < 20 && reqReady !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			if (rspValid === 1'b1) rspSeen++;
		end
		chk(reqReady, 1);
		chk(i, expCyc);
	endtask : xfer
	// After reset every strobe is idle and nothing drives the bus
	task t_reset_idle;
		chk({byteEnable_n, command_n}, 5'h1f);
		chk({statusLineA_n, statusLineB_n, dmaFinalCountPulse_n}, 3'h7);
		chk({busAddrOe, dataOe, rspValid, reqReady}, 4'h1);
	endtask : t_reset_idle
	task t_io_write;
		xfer(1, 0, 0, 24'h000101, 32'h1234abcd, 4'h2);
		chk(wrData, 32'h1234abcd);
		chk(wrAddr, 25'h0000101);
		chk(fcSeen, 0);
		chk(rspSeen, 0);
	endtask : t_io_write
	task t_mem_read_last;
		xfer(0, 1, 1, 24'h00abc0, 32'h0, 4'hf);
		chk(rspData, 32'h5a00abc0);
		chk(rspSeen, 1);
		chk(fcSeen, 1);
	endtask : t_mem_read_last
	// Back to back: zero-data memory write near the top address, then an I/O read
	task t_back_to_back;
		xfer(1, 1, 0, 24'hfffffe, 32'h0, 4'h1);
		chk(wrAddr, 25'h1fffffe);
		chk(wrData, 0);
		xfer(0, 0, 0, 24'h000003, 32'hffffffff, 4'h8);
		chk(rspData, 32'h5a000003);
		chk(rspSeen, 1);
	endtask : t_back_to_back
	// Ceiling far above the 36 cycles the scenarios need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			errTotal++;
			reportAndStop();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 0;
		t_reset_idle();
		t_io_write();
		t_mem_read_last();
		t_back_to_back();
		reportAndStop();
	end
endmodule : test_cxm_master
`default_nettype wire

// ===== rtl/cxm_master.sv
// Controlling master that runs read and write cycles on the channel bus
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] I/O write: master holds data through command
// [R2] I/O read: slave drives data inside command
// [R3] Memory write: master holds data through command
// [R4] Memory read: slave drives data inside command
// [R5] Writes: address valid before status line a
// [R6] Reads: address valid before status line b
// [R7] High lane enable with address bit 0; the code takes it from byte enables 1 and 3 instead
// [R8] 16-bit slaves decode lane enable, 8-bit don't
// [R9] Final count pulses within a DMA command
// [R10] 32-bit master holds translate inactive, drives enables
// [R11] Status pair plus memory select decode cycle
// [R12] Command trailing edge ends bus cycle
// [R13] Slave floats data except during reads
module cxm_master #(
	parameter int ADDR_W = cxm_pkg::ADDR_W,
	parameter int DATA_W = cxm_pkg::DATA_W,
	parameter int BE_W = cxm_pkg::BE_W
) (
	input wire logic clk,
	input wire logic rst,
	// User request side
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqWrite,
	input wire logic reqMemory,
	input wire logic reqLast,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	input wire logic [BE_W-1:0] reqByteEn,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	// Channel pins
	output logic [ADDR_W-1:0] busAddr,
	output logic busAddrOe,
	output logic memIoSelect,
	output logic statusLineA_n,
	output logic statusLineB_n,
	output logic command_n,
	output logic highByteLaneEnable_n,
	output logic [BE_W-1:0] byteEnable_n,
	output logic byteEnableTranslateSelect_n,
	output logic dmaFinalCountPulse_n,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe,
	input wire logic [DATA_W-1:0] dataIn
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// The lane logic is written for a 32-bit data path with four
	// enables; other widths would need a lane steering stage
	if (DATA_W != cxm_pkg::DATA_W || BE_W != cxm_pkg::BE_W ||
		ADDR_W < 2) begin : g_badWidth
		$error("cxm_master: unsupported bus widths");
	end
	// Each phase count must fit the down-counter or a phase is cut short
	if (cxm_pkg::ADDR_SETUP_CYC > (1 << cxm_pkg::CNT_W) ||
		cxm_pkg::CMD_WIDTH_CYC > (1 << cxm_pkg::CNT_W) ||
		cxm_pkg::HOLD_CYC > (1 << cxm_pkg::CNT_W)) begin : g_badCount
		$error("cxm_master: phase count too wide for counter");
	end

	// ------------------------------------------------------------
	// Data pin synchroniser
	// ------------------------------------------------------------
	// Slave data arrives unclocked; two stages before sampling
	// The word is taken from the second stage with no check that it stood still,
	// so bits that skew across the first stage can still mix two values
	logic [DATA_W-1:0] dataSync1;
	logic [DATA_W-1:0] dataSync2;
	always_ff @(posedge clk) begin
		dataSync1 <= dataIn;
		dataSync2 <= dataSync1;
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	cxm_pkg::cxm_state_type state;
	cxm_pkg::cxm_state_type next_state;
	logic [cxm_pkg::CNT_W-1:0] count;
	logic [cxm_pkg::CNT_W-1:0] next_count;
	logic curWrite;
	logic curMemory;
	logic curLast;
	logic [ADDR_W-1:0] curAddr;
	logic [DATA_W-1:0] curData;
	logic [BE_W-1:0] curByteEn;

	wire logic isIdle = (state == cxm_pkg::ST_IDLE);
	wire logic accept = isIdle && reqValid;
	wire logic countDone = (count == '0);
	// Sample late in the command so slave data has settled across sync
	wire logic sampleNow = (state == cxm_pkg::ST_CMD) && countDone &&
		!curWrite; // [R2] [R4]

	// One cycle walks address, status, command and hold phases; the
	// counter only runs down inside a phase and sits at zero elsewhere
	// Next-state choice and phase counts
	always_comb begin
		next_state = state;
		next_count = countDone ? count : count - 1'b1;
		case (state)
			cxm_pkg::ST_IDLE: begin
				if (reqValid) begin
					next_state = cxm_pkg::ST_ADDR;
					next_count = cxm_pkg::CNT_W'(cxm_pkg::ADDR_SETUP_CYC - 1);
				end
			end
			cxm_pkg::ST_ADDR: begin
				// Address settles before any status line falls
				if (countDone) begin // [R5] [R6]
					next_state = cxm_pkg::ST_STAT;
					next_count = '0;
				end
			end
			cxm_pkg::ST_STAT: begin
				next_state = cxm_pkg::ST_CMD;
				next_count = cxm_pkg::CNT_W'(cxm_pkg::CMD_WIDTH_CYC - 1);
			end
			cxm_pkg::ST_CMD: begin
				if (countDone) begin
					next_state = cxm_pkg::ST_HOLD;
					next_count = cxm_pkg::CNT_W'(cxm_pkg::HOLD_CYC - 1);
				end
			end
			cxm_pkg::ST_HOLD: begin
				// Command has risen: cycle over, data still held one phase
				if (countDone) begin // [R12]
					next_state = cxm_pkg::ST_IDLE;
					next_count = '0;
				end
			end
			default: begin
				next_state = cxm_pkg::ST_IDLE;
				next_count = '0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= cxm_pkg::ST_IDLE;
			count <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Request capture; held steady for the whole cycle
	// Pins come from these copies, never straight from the request side
	always_ff @(posedge clk) begin
		if (rst) begin
			curWrite <= 1'b0;
			curMemory <= 1'b0;
			curLast <= 1'b0;
			curAddr <= '0;
			curData <= '0;
			curByteEn <= '0;
		end else if (accept) begin
			curWrite <= reqWrite;
			curMemory <= reqMemory;
			curLast <= reqLast;
			curAddr <= reqAddr;
			curData <= reqData;
			curByteEn <= reqByteEn;
		end
	end

	// Read data return
	// rspData holds until the next read so a slow user can still take it
	always_ff @(posedge clk) begin
		if (rst) begin
			rspValid <= 1'b0;
			rspData <= '0;
		end else begin
			rspValid <= sampleNow;
			if (sampleNow)
				rspData <= dataSync2;
		end
	end

	// ------------------------------------------------------------
	// Pin decode
	// ------------------------------------------------------------
	wire logic inCycle = !isIdle;
	wire logic statusOn = (state == cxm_pkg::ST_STAT) ||
		(state == cxm_pkg::ST_CMD);
	wire logic cmdOn = (state == cxm_pkg::ST_CMD);
	wire logic [1:0] statusCode = !statusOn ? cxm_pkg::STAT_IDLE :
		(curWrite ? cxm_pkg::STAT_WRITE : cxm_pkg::STAT_READ); // [R11]
	// Upper lane when any of bytes 1 or 3 is wanted
	// Address bit 0 already travels on the bus for narrow slaves; the
	// enables say which lanes carry data, so bit 0 is not read here
	wire logic highLane = curByteEn[1] || curByteEn[3]; // [R7] [R8]

	assign reqReady = isIdle;
	assign busAddr = curAddr;
	assign busAddrOe = inCycle;
	assign memIoSelect = curMemory; // [R11]
	assign statusLineA_n = statusCode[0]; // [R5]
	assign statusLineB_n = statusCode[1]; // [R6]
	assign command_n = !cmdOn; // [R12]
	assign highByteLaneEnable_n = !(inCycle && highLane); // [R7]
	// We act as a 32-bit master: translator stays off, we own enables
	// Enables rest high between cycles so no lane looks selected
	assign byteEnableTranslateSelect_n = 1'b1; // [R10]
	assign byteEnable_n = inCycle ? ~curByteEn : cxm_pkg::BE_ALL; // [R10]
	assign dmaFinalCountPulse_n = !(cmdOn && curLast); // [R9]
	// Write data from address phase through hold, floated for reads
	assign dataOut = curData; // [R1] [R3]
	assign dataOe = inCycle && curWrite; // [R1] [R3] [R13]

endmodule : cxm_master
`default_nettype wire

// ===== rtl/cxm_pkg.sv
// Package of constants for the channel bus master cycle controller
package cxm_pkg;
	// Bus widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	// Cycle phase timing in nanoseconds, the figures are our own choice
	localparam int CLK_NS = 100;
	localparam int ADDR_SETUP_NS = 100;
	localparam int CMD_WIDTH_NS = 300;
	localparam int HOLD_NS = 100;
	// Least times round up to whole cycles, never below one
	localparam int ADDR_SETUP_CYC =
		(ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CMD_WIDTH_CYC =
		(CMD_WIDTH_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(CMD_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC =
		(HOLD_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 4;
	// Status line levels (active low) for a write and for a read
	localparam logic [1:0] STAT_IDLE = 2'h3;  // {b, a}
	localparam logic [1:0] STAT_WRITE = 2'h2; // line a low alone
	localparam logic [1:0] STAT_READ = 2'h1;  // line b low alone
	localparam logic [3:0] BE_ALL = 4'hf;
	localparam logic [7:0] LANE_ZERO = 8'h00;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_STAT = 5'h04,
		ST_CMD = 5'h08,
		ST_HOLD = 5'h10
	} cxm_state_type;
endpackage : cxm_pkg
